// [rtl/host_port_consts.svh]
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// Width of the multiplexed address/data bus
`define BUS_W          16
// Strobe style select encodings
`define STYLE_LATCH    1'b0
`define STYLE_PULSE    1'b1
// Bus control select encodings for the request pin
`define CTL_HOLD_OD    1'b0
`define CTL_REQ_ALT    1'b1
// Port select encodings
`define PORT_DATA      1'b0
`define PORT_ADDR      1'b1
// Synchroniser reset image: grant, cs_n, port, das, rw, ready, bus
`define SYNC_RST       22'h3D0000

`endif

// [rtl/host_port_pkg.sv]
`include "host_port_consts.svh"

package host_port_pkg;

    typedef enum logic [5:0] {
        M_IDLE = 6'h01,
        M_REQ  = 6'h02,
        M_ADDR = 6'h04,
        M_DATA = 6'h08,
        M_END  = 6'h10,
        M_REL  = 6'h20
    } mst_state_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_ACT  = 3'h2,
        S_HOLD = 3'h4
    } slv_state_t;

    typedef struct packed {
        logic                rd;
        logic [`BUS_W-1:0]   addr;
        logic [`BUS_W-1:0]   wdata;
    } master_req_t;

    typedef struct packed {
        logic                port;
        logic                wr;
        logic [`BUS_W-1:0]   data;
    } slave_acc_t;

endpackage : host_port_pkg

// [rtl/pin_sync.sv]
`timescale 1ns/10ps

// Three-stage input synchroniser; a bit changes only once stages two and three agree
module pin_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q_ff <= RST;
        end else begin
            q_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
        end
    end

    assign q = q_ff;
endmodule : pin_sync

// [rtl/host_bus_handshake_port.sv]
// Behaviour
// - With latch style the strobe is high in the address phase and low through the data phase.
// - With pulse style the strobe pulses low only in the address phase, inverse to latch style.
// - The strobe is driven only while the device is bus master and floats otherwise.
// - Master transfers start only after a low grant is seen following the bus request.
// - A low chip select makes the device the slave and must stay stable for the access.
// - A slave access goes to the data port when port select is low, the address port when high.
// - Port select is used only while chip select is low and must hold through the data phase.
// - The bus control select bit chooses the function of the request pin.
// - As slave, ready answers the data strobe and is released once strobe or chip select ends.
// - As slave the device drives data when read/write is high; as master the sense is reversed.
// - Data is valid at the strobe rise; driven as master on writes and as slave on reads, input in the other direction, floated otherwise.
`timescale 1ns/10ps
`include "host_port_consts.svh"

module host_bus_handshake_port
    import host_port_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               strobe_style_sel,
    input  wire logic               bus_ctl_sel,
    input  wire logic               m_start,
    input  wire master_req_t        m_req,
    output logic                    m_busy_ff,
    output logic                    m_done_ff,
    output logic [`BUS_W-1:0]       m_rdata_ff,
    output logic                    slv_valid_ff,
    output slave_acc_t              slv_acc_ff,
    input  wire logic [`BUS_W-1:0]  slv_rd_data,
    input  wire logic [`BUS_W-1:0]  muxed_addr_data_bus_in,
    output logic [`BUS_W-1:0]       muxed_addr_data_bus_out_ff,
    output logic                    muxed_addr_data_bus_oe_n_ff,
    input  wire logic               rw_in,
    output logic                    rw_out_ff,
    output logic                    rw_oe_n_ff,
    input  wire logic               data_phase_strobe_in,
    output logic                    data_phase_strobe_out_ff,
    output logic                    data_phase_strobe_oe_n_ff,
    output logic                    addr_pulse_strobe_out_ff,
    output logic                    addr_pulse_strobe_oe_n_ff,
    input  wire logic               bus_req_alt_in,
    output logic                    bus_req_alt_out_ff,
    output logic                    bus_req_alt_oe_n_ff,
    input  wire logic               bus_grant_in,
    input  wire logic               cs_n_in,
    input  wire logic               port_sel_in,
    input  wire logic               ready_n_in,
    output logic                    ready_n_out_ff,
    output logic                    ready_n_oe_n_ff
);
    logic               grant_s;
    logic               cs_n_s;
    logic               psel_s;
    logic               das_s;
    logic               rw_s;
    logic               rdy_s;
    logic [`BUS_W-1:0]  bus_s;
    mst_state_t         mst_ff;
    mst_state_t         nxt_mst;
    slv_state_t         slv_ff;
    slv_state_t         nxt_slv;
    master_req_t        mreq_ff;
    logic [`BUS_W-1:0]  slv_rd_ff;

    // Request pin is only observed by the arbiter; its readback is not needed here
    pin_sync #(.W(22), .RST(`SYNC_RST)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({bus_grant_in, cs_n_in, port_sel_in, data_phase_strobe_in,
                 rw_in, ready_n_in, muxed_addr_data_bus_in}),
        .q     ({grant_s, cs_n_s, psel_s, das_s, rw_s, rdy_s, bus_s})
    );

    function automatic logic owns_bus(input mst_state_t s);
        owns_bus = (s == M_ADDR) || (s == M_DATA) || (s == M_END);
    endfunction : owns_bus

    function automatic logic requesting(input mst_state_t s);
        requesting = owns_bus(s) || (s == M_REQ);
    endfunction : requesting

    always_comb begin
        nxt_mst = mst_ff;
        case (mst_ff)
            M_IDLE: if (m_start && slv_ff == S_IDLE) nxt_mst = M_REQ;
            M_REQ:  if (!grant_s) nxt_mst = M_ADDR;
            M_ADDR: nxt_mst = M_DATA;
            M_DATA: if (!rdy_s) nxt_mst = M_END;
            M_END:  nxt_mst = M_REL;
            // Wait for the arbiter to withdraw grant so a stale low is not taken as a new grant
            M_REL:  if (grant_s) nxt_mst = M_IDLE;
            default: nxt_mst = M_IDLE;
        endcase
    end

    always_comb begin
        nxt_slv = slv_ff;
        case (slv_ff)
            S_IDLE: if (mst_ff == M_IDLE && !m_start && !cs_n_s && !das_s) begin
                nxt_slv = S_ACT;
            end
            S_ACT:  nxt_slv = S_HOLD;
            S_HOLD: if (das_s || cs_n_s) nxt_slv = S_IDLE;
            default: nxt_slv = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mst_ff <= M_IDLE;
            slv_ff <= S_IDLE;
        end else begin
            mst_ff <= nxt_mst;
            slv_ff <= nxt_slv;
        end
    end

    // Master request capture, read data and user status
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mreq_ff    <= '0;
            m_busy_ff  <= 1'b0;
            m_done_ff  <= 1'b0;
            m_rdata_ff <= '0;
        end else begin
            if (mst_ff == M_IDLE && nxt_mst == M_REQ) mreq_ff <= m_req;
            if (mst_ff == M_DATA && nxt_mst == M_END && mreq_ff.rd) m_rdata_ff <= bus_s;
            m_busy_ff <= (nxt_mst != M_IDLE);
            m_done_ff <= (mst_ff == M_REL) && (nxt_mst == M_IDLE);
        end
    end

    // Slave capture; the port select is only looked at with chip select low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            slv_valid_ff <= 1'b0;
            slv_acc_ff   <= '0;
            slv_rd_ff    <= '0;
        end else begin
            slv_valid_ff <= (slv_ff == S_IDLE) && (nxt_slv == S_ACT);
            if (slv_ff == S_IDLE && nxt_slv == S_ACT) begin
                slv_acc_ff.port <= psel_s ? `PORT_ADDR : `PORT_DATA;
                slv_acc_ff.wr   <= !rw_s;
                slv_acc_ff.data <= bus_s;
            end
            if (slv_ff == S_ACT) slv_rd_ff <= slv_rd_data;
        end
    end

    // Strobe and request pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_pulse_strobe_out_ff  <= 1'b1;
            addr_pulse_strobe_oe_n_ff <= 1'b1;
            bus_req_alt_out_ff        <= 1'b1;
            bus_req_alt_oe_n_ff       <= 1'b1;
        end else begin
            if (nxt_mst == M_ADDR) begin
                addr_pulse_strobe_out_ff <= (strobe_style_sel == `STYLE_LATCH);
            end else begin
                addr_pulse_strobe_out_ff <= (strobe_style_sel == `STYLE_PULSE);
            end
            addr_pulse_strobe_oe_n_ff <= !owns_bus(nxt_mst);
            bus_req_alt_out_ff <= !requesting(nxt_mst);
            // Open-drain hold style lets several requesters share the line
            if (bus_ctl_sel == `CTL_HOLD_OD) begin
                bus_req_alt_oe_n_ff <= !requesting(nxt_mst);
            end else begin
                bus_req_alt_oe_n_ff <= 1'b0;
            end
        end
    end

    // Data strobe, read/write and bus direction
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            data_phase_strobe_out_ff    <= 1'b1;
            data_phase_strobe_oe_n_ff   <= 1'b1;
            rw_out_ff                   <= 1'b0;
            rw_oe_n_ff                  <= 1'b1;
            muxed_addr_data_bus_out_ff  <= '0;
            muxed_addr_data_bus_oe_n_ff <= 1'b1;
        end else begin
            data_phase_strobe_out_ff  <= (nxt_mst != M_DATA);
            data_phase_strobe_oe_n_ff <= !owns_bus(nxt_mst);
            rw_out_ff                 <= mreq_ff.rd;
            rw_oe_n_ff                <= !owns_bus(nxt_mst);
            if (nxt_mst == M_ADDR) begin
                muxed_addr_data_bus_out_ff  <= mreq_ff.addr;
                muxed_addr_data_bus_oe_n_ff <= 1'b0;
            end else if (owns_bus(nxt_mst)) begin
                // Write data held through the strobe's rising edge
                muxed_addr_data_bus_out_ff  <= mreq_ff.wdata;
                muxed_addr_data_bus_oe_n_ff <= mreq_ff.rd;
            end else if (nxt_slv == S_HOLD) begin
                muxed_addr_data_bus_out_ff  <= (slv_ff == S_ACT) ? slv_rd_data : slv_rd_ff;
                muxed_addr_data_bus_oe_n_ff <= slv_acc_ff.wr;
            end else begin
                muxed_addr_data_bus_oe_n_ff <= 1'b1;
            end
        end
    end

    // Slave ready, open drain
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ready_n_out_ff  <= 1'b1;
            ready_n_oe_n_ff <= 1'b1;
        end else begin
            ready_n_out_ff  <= !(nxt_slv == S_HOLD);
            ready_n_oe_n_ff <= !(nxt_slv == S_HOLD);
        end
    end

    property p_latch_data_low;
        @(posedge clock) disable iff (!rst_n)
        (owns_bus(mst_ff) && mst_ff != M_ADDR && strobe_style_sel == `STYLE_LATCH)
            |-> (addr_pulse_strobe_out_ff == 1'b0);
    endproperty
    a_latch_data_low: assert property (p_latch_data_low)
        else $error("latch strobe not low in data phase");

    property p_pulse_addr_low;
        @(posedge clock) disable iff (!rst_n)
        (mst_ff == M_ADDR && strobe_style_sel == `STYLE_PULSE && $stable(strobe_style_sel))
            |-> (addr_pulse_strobe_out_ff == 1'b0) ##1 (addr_pulse_strobe_out_ff == 1'b1);
    endproperty
    a_pulse_addr_low: assert property (p_pulse_addr_low)
        else $error("pulse strobe shape wrong");

    property p_strobe_float;
        @(posedge clock) disable iff (!rst_n)
        (mst_ff == M_IDLE || mst_ff == M_REQ || mst_ff == M_REL) |-> addr_pulse_strobe_oe_n_ff;
    endproperty
    a_strobe_float: assert property (p_strobe_float)
        else $error("strobe driven while not master");

    property p_grant_first;
        @(posedge clock) disable iff (!rst_n)
        $fell(addr_pulse_strobe_oe_n_ff) |-> ($past(grant_s) == 1'b0 && $past(mst_ff) == M_REQ);
    endproperty
    a_grant_first: assert property (p_grant_first)
        else $error("master cycle without grant");

    property p_port_map;
        @(posedge clock) disable iff (!rst_n)
        slv_valid_ff |-> (slv_acc_ff.port == ($past(psel_s) ? `PORT_ADDR : `PORT_DATA))
                         && ($past(cs_n_s) == 1'b0);
    endproperty
    a_port_map: assert property (p_port_map)
        else $error("slave port select mismatch");

    property p_req_hold_style;
        @(posedge clock) disable iff (!rst_n)
        (mst_ff == M_REQ && bus_ctl_sel == `CTL_HOLD_OD && $stable(bus_ctl_sel))
            |-> (!bus_req_alt_out_ff && !bus_req_alt_oe_n_ff);
    endproperty
    a_req_hold_style: assert property (p_req_hold_style)
        else $error("request pin not asserted");

    property p_ready_release;
        @(posedge clock) disable iff (!rst_n)
        (slv_ff == S_HOLD && (das_s || cs_n_s)) |=> (ready_n_oe_n_ff && slv_ff == S_IDLE);
    endproperty
    a_ready_release: assert property (p_ready_release)
        else $error("ready not released");

    property p_slave_drive;
        @(posedge clock) disable iff (!rst_n)
        (slv_ff == S_HOLD && !muxed_addr_data_bus_oe_n_ff) |-> (slv_acc_ff.wr == 1'b0);
    endproperty
    a_slave_drive: assert property (p_slave_drive)
        else $error("slave drove bus on write");

    property p_das_rise;
        @(posedge clock) disable iff (!rst_n)
        (mst_ff == M_END) |-> (data_phase_strobe_out_ff && !$past(data_phase_strobe_out_ff)
                               && !data_phase_strobe_oe_n_ff);
    endproperty
    a_das_rise: assert property (p_das_rise)
        else $error("data strobe not rising at end");

    property p_ready_ends;
        @(posedge clock) disable iff (!rst_n)
        (mst_ff == M_DATA && !rdy_s)
            |=> (mst_ff == M_END) ##2 (mst_ff == M_REL || mst_ff == M_IDLE);
    endproperty
    a_ready_ends: assert property (p_ready_ends)
        else $error("ready did not end data phase");

endmodule : host_bus_handshake_port

// [bench/host_bus_partner.sv]
`timescale 1ns/10ps
`include "host_port_consts.svh"

module host_bus_partner (
    input  wire logic              clock,
    input  wire logic              style,
    input  wire logic [`BUS_W-1:0] bus_o,
    input  wire logic              bus_oe_n,
    input  wire logic              rw_o,
    input  wire logic              rw_oe_n,
    input  wire logic              das_o,
    input  wire logic              das_oe_n,
    input  wire logic              stb_o,
    input  wire logic              stb_oe_n,
    input  wire logic              req_o,
    input  wire logic              req_oe_n,
    input  wire logic              rdy_o,
    input  wire logic              rdy_oe_n,
    output logic [`BUS_W-1:0]      bus,
    output logic                   rw,
    output logic                   data_phase_strobe,
    output logic                   req_n,
    output logic                   grant_n,
    output logic                   cs_n,
    output logic                   port_sel,
    output logic                   ready_n
);
    logic [`BUS_W-1:0] h_bus, mem_rd, m_addr, last_addr, last_wdata;
    logic [`BUS_W-1:0] last_bus = '0;
    logic h_bus_en = 0, h_rw = 0, h_das = 1, mem_drv = 0, mem_rdy_n = 1, das_q = 1;
    int gdly = 0, rdly = 0, viol = 0;

    initial begin
        cs_n = 1;
        port_sel = 0;
        grant_n = 1;
    end

    // A released bus shows a changing pattern so a stale value never passes
    assign bus = !bus_oe_n ? bus_o : h_bus_en ? h_bus : mem_drv ? mem_rd : ~last_bus;
    assign rw = !rw_oe_n ? rw_o : h_rw;
    assign data_phase_strobe = !das_oe_n ? das_o : h_das;
    // Request and ready are open drain with pull-ups
    assign req_n = req_oe_n | req_o;
    assign ready_n = (rdy_oe_n | rdy_o) & mem_rdy_n;

    always @(posedge clock) begin
        last_bus <= bus;
        #1;
        if (!stb_oe_n && grant_n) viol++;
        if (!req_n && grant_n) begin
            if (gdly == 0) grant_n = 0;
            else gdly--;
        end else if (req_n && !grant_n) begin
            grant_n = 1;
            gdly = $urandom_range(3, 0);
        end
        if (!stb_oe_n && stb_o !== style && !das_oe_n && das_o) m_addr = bus;
        if (!stb_oe_n && stb_o !== style && !das_oe_n && !das_o) viol++;
        if (!das_oe_n && !das_o) begin
            if (rdy_n_due()) begin
                mem_rdy_n = 0;
                mem_drv = rw;
                mem_rd = ~m_addr;
            end
        end else begin
            if (!das_q) begin
                last_addr = m_addr;
                last_wdata = bus;
            end
            mem_rdy_n = 1;
            mem_drv = 0;
            rdly = $urandom_range(4, 0);
        end
        das_q = das_oe_n | das_o;
    end

    function automatic logic rdy_n_due();
        if (rdly == 0) return 1'b1;
        rdly--;
        return 1'b0;
    endfunction : rdy_n_due

    task automatic host_access(input logic port, input logic wr, input logic [`BUS_W-1:0] d,
                               output logic [`BUS_W-1:0] rd, output logic ok);
        int n;
        cs_n = 0;
        port_sel = port;
        h_rw = !wr;
        h_bus = d;
        h_bus_en = wr;
        @(posedge clock);
        #1;
        h_das = 0;
        ok = 0;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge clock);
            #1;
            ok = !ready_n;
        end
        rd = bus;
        h_das = 1;
        for (n = 0; n < 10 && !ready_n; n++) begin
            @(posedge clock);
            #1;
        end
        ok = ok && ready_n;
        cs_n = 1;
        h_bus_en = 0;
        port_sel = ~port;
        @(posedge clock);
        #1;
    endtask : host_access
endmodule : host_bus_partner

// [bench/tb.sv]
`timescale 1ns/10ps
`include "host_port_consts.svh"

module tb;
    import host_port_pkg::*;
    logic clock = 0, rst_n = 0, style = 0, ctl = 0, m_start = 0, ok;
    master_req_t m_req = '0, me, ms;
    logic [`BUS_W-1:0] slv_rd_data = '0, m_rdata, bus_o, bus, hrd;
    logic m_busy, m_done, slv_valid, bus_oe_n, rw_o, rw_oe_n, das_o, das_oe_n, stb_o, stb_oe_n;
    logic req_o, req_oe_n, rdy_o, rdy_oe_n, rw, data_phase_strobe, req_n, grant_n, cs_n, port_sel, ready_n;
    slave_acc_t slv_acc, se, ss;
    master_req_t mq[$];
    slave_acc_t sq[$];
    int error_cnt = 0, cmp_count = 0, i;

    always #4 clock = ~clock;

    host_bus_handshake_port host_bus_handshake_port_i (
        .clock(clock), .rst_n(rst_n), .strobe_style_sel(style), .bus_ctl_sel(ctl),
        .m_start(m_start), .m_req(m_req), .m_busy_ff(m_busy), .m_done_ff(m_done),
        .m_rdata_ff(m_rdata), .slv_valid_ff(slv_valid), .slv_acc_ff(slv_acc),
        .slv_rd_data(slv_rd_data), .muxed_addr_data_bus_in(bus),
        .muxed_addr_data_bus_out_ff(bus_o), .muxed_addr_data_bus_oe_n_ff(bus_oe_n),
        .rw_in(rw), .rw_out_ff(rw_o), .rw_oe_n_ff(rw_oe_n), .data_phase_strobe_in(data_phase_strobe),
        .data_phase_strobe_out_ff(das_o), .data_phase_strobe_oe_n_ff(das_oe_n),
        .addr_pulse_strobe_out_ff(stb_o), .addr_pulse_strobe_oe_n_ff(stb_oe_n),
        .bus_req_alt_in(req_n), .bus_req_alt_out_ff(req_o), .bus_req_alt_oe_n_ff(req_oe_n),
        .bus_grant_in(grant_n), .cs_n_in(cs_n), .port_sel_in(port_sel),
        .ready_n_in(ready_n), .ready_n_out_ff(rdy_o), .ready_n_oe_n_ff(rdy_oe_n)
    );

    host_bus_partner p_i (
        .clock(clock), .style(style), .bus_o(bus_o), .bus_oe_n(bus_oe_n), .rw_o(rw_o),
        .rw_oe_n(rw_oe_n), .das_o(das_o), .das_oe_n(das_oe_n), .stb_o(stb_o),
        .stb_oe_n(stb_oe_n), .req_o(req_o), .req_oe_n(req_oe_n), .rdy_o(rdy_o),
        .rdy_oe_n(rdy_oe_n), .bus(bus), .rw(rw), .data_phase_strobe(data_phase_strobe), .req_n(req_n),
        .grant_n(grant_n), .cs_n(cs_n), .port_sel(port_sel), .ready_n(ready_n)
    );

    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp_mst(input master_req_t e, input master_req_t s);
        cmp_count++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD master_xfer exp %h seen %h", e, s);
        end
    endtask : cmp_mst

    task automatic cmp_slv(input slave_acc_t e, input slave_acc_t s);
        cmp_count++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD slave_acc exp %h seen %h", e, s);
        end
    endtask : cmp_slv

    task automatic cmp_val(input string n, input logic [`BUS_W-1:0] e, input logic [`BUS_W-1:0] s);
        cmp_count++;
        if (e !== s) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : cmp_val

    task automatic master_xfer(input logic rd);
        int n;
        m_req.rd = rd;
        m_req.addr = 16'($urandom);
        m_req.wdata = 16'($urandom);
        me = m_req;
        if (rd) me.wdata = ~m_req.addr;
        mq.push_back(me);
        m_start = 1;
        @(posedge clock);
        #1;
        m_start = 0;
        for (n = 0; n < 300 && m_done !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 300) begin
            cmp_val("master_done", 16'h0001, 16'h0000);
            print_verdict();
        end
    endtask : master_xfer

    task automatic slave_xfer(input logic port, input logic wr);
        logic [`BUS_W-1:0] d;
        d = 16'($urandom);
        slv_rd_data = 16'($urandom);
        se.port = port;
        se.wr = wr;
        se.data = d;
        sq.push_back(se);
        p_i.host_access(port, wr, d, hrd, ok);
        cmp_val("slave_ready", 16'h0001, {15'h0000, ok});
        if (!ok) print_verdict();
        if (!wr) cmp_val("slave_rdata", slv_rd_data, hrd);
    endtask : slave_xfer

    // Results are paired with the oldest note as they appear
    always @(posedge clock) begin
        #2;
        if (m_done === 1'b1 && mq.size() > 0) begin
            me = mq.pop_front();
            ms = me;
            ms.addr = p_i.last_addr;
            ms.wdata = me.rd ? m_rdata : p_i.last_wdata;
            cmp_mst(me, ms);
        end else if (m_done === 1'b1) cmp_mst('0, '1);
        if (slv_valid === 1'b1 && sq.size() > 0) begin
            ss = sq.pop_front();
            se = slv_acc;
            if (!ss.wr) se.data = ss.data;
            cmp_slv(ss, se);
        end else if (slv_valid === 1'b1) cmp_slv('0, '1);
    end

    initial begin
        void'($urandom(81));
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1;
        for (i = 0; i < 4; i++) begin
            {style, ctl} = 2'(i);
            repeat (8) @(posedge clock);
            #1;
            cmp_val("req_idle", {14'h0000, !ctl, 1'b1}, {14'h0000, req_oe_n, req_n});
            cmp_val("strobe_float", 16'h0001, {15'h0000, stb_oe_n});
            master_xfer(1'b0);
            master_xfer(1'b1);
            master_xfer(1'b1);
        end
        for (i = 0; i < 4; i++) slave_xfer(i[1], i[0]);
        repeat (4) begin
            p_i.h_das = ~p_i.h_das;
            p_i.port_sel = ~p_i.port_sel;
            repeat (6) @(posedge clock);
            #1;
        end
        fork
            slave_xfer(1'b1, 1'b1);
            begin
                repeat (9) @(posedge clock);
                #1;
                m_start = 1;
                @(posedge clock);
                #1;
                m_start = 0;
                @(posedge clock);
                #1;
                cmp_val("refused_busy", 16'h0000, {15'h0000, m_busy});
            end
        join
        repeat (30) @(posedge clock);
        #1;
        cmp_val("partner_viol", 16'h0000, 16'(p_i.viol));
        print_verdict();
    end
endmodule : tb
